// ---- msl_map.svh ----
// Register offsets, field positions, reset values and timing counts of the
// modem host serial line controller.
// Assumes inclusion by bare name from the controller source.
`ifndef MSL_MAP_SVH
`define MSL_MAP_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MSL_REG_CTRL 8'h00
`define MSL_REG_BAUD 8'h04
`define MSL_REG_TOFF 8'h08
`define MSL_REG_STAT 8'h0c

// ****************************************************************
// Control fields
// ****************************************************************
`define MSL_CTRL_EN 0
`define MSL_CTRL_LINE_LO 1
`define MSL_CTRL_LINE_HI 2
`define MSL_CTRL_OP_LO 3
`define MSL_CTRL_OP_HI 5
`define MSL_CTRL_DTRC 6
`define MSL_CTRL_RTSC 7
`define MSL_CTRL_RST 8'h01
`define MSL_LINE_RS232 2'h0
`define MSL_LINE_RS422 2'h1
`define MSL_LINE_RS485 2'h2
`define MSL_OP_SWITCHABLE 3'h6

// ****************************************************************
// Status fields
// ****************************************************************
`define MSL_STAT_OVR 8
`define MSL_STAT_FRM 9

// ****************************************************************
// Timing
// ****************************************************************
`define MSL_CLK_HZ 40000000
`define MSL_BAUD_RST_RATE 115200
`define MSL_BAUD_DIV_RST 16'(`MSL_CLK_HZ / `MSL_BAUD_RST_RATE)
`define MSL_TOFF_RST 4'h4
`define MSL_CHAR_BITS 4'ha
`define MSL_QUARTERS 20'h0000a
`define MSL_BUS_IDLE_Q 3'h4
`define MSL_FIFO_DEPTH 32
`define MSL_FIFO_CW 6

`endif

// ---- msl_pkg.sv ----
// Types of the modem host serial line controller.
// Assumes nothing of its surroundings.
package msl_pkg;
    typedef enum logic [1:0] {
        MSL_TX_IDLE,
        MSL_TX_WAIT_BUS,
        MSL_TX_SHIFT,
        MSL_TX_HOLD
    } msl_tx_state_e;

    typedef enum logic [1:0] {
        MSL_RX_IDLE,
        MSL_RX_START,
        MSL_RX_DATA,
        MSL_RX_STOP
    } msl_rx_state_e;
endpackage

// ---- msl_serial_ctrl.sv ----
// Host serial line controller of a wireless data modem, with its receive FIFO.
// Assumes one 40 MHz clock, inputs synchronous to it, AXI4-Lite register access.
//
// The placing of the registers and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "msl_map.svh"

// ****************************************************************
// Receive FIFO
// ****************************************************************
module msl_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW = 6
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [CW-1:0] count
);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [CW-2:0] wr_ptr_r;
    logic [CW-2:0] rd_ptr_r;
    logic [CW-1:0] count_r;
    logic do_wr;
    logic do_rd;

    assign in_ready = (count_r != CW'(DEPTH));
    assign out_valid = (count_r != '0);
    assign out_data = mem[rd_ptr_r];
    assign count = count_r;
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    always_ff @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (do_wr) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (do_rd) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (do_wr && !do_rd) begin
                count_r <= count_r + 1'b1;
            end else if (do_rd && !do_wr) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule

module msl_serial_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // AXI4-Lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    // AXI4-Lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    // AXI4-Lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Host serial pins
    output logic txd_out,
    input wire logic rxd_in,
    output logic cd_out,
    output logic cts_out,
    input wire logic dtr_in,
    input wire logic rts_in,
    output logic line_drv_en,
    // Radio side
    input wire logic link_up,
    input wire logic radio_tx_valid,
    output logic radio_tx_ready,
    input wire logic [7:0] radio_tx_data,
    output logic radio_rx_valid,
    input wire logic radio_rx_ready,
    output logic [7:0] radio_rx_data,
    output logic dtr_ctl,
    output logic rts_ctl
);
    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic aw_held_r, w_held_r, bvalid_r, rvalid_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rdata_r;
    logic [3:0] w_strb_r;
    logic [1:0] bresp_r, rresp_r;
    logic [7:0] ctrl_r;
    logic [15:0] baud_r;
    logic [3:0] toff_r;
    logic ovr_r, frm_r;
    logic do_write, rd_take;
    logic [31:0] wr_merge, rd_mux;
    logic rd_hit, wr_hit;
    logic enable, mode422, mode485;
    logic [19:0] q_len, q_cnt_r;
    logic q_tick, q_restart;
    logic [2:0] idle_q_r;
    logic bus_idle_ok;
    msl_pkg::msl_tx_state_e tx_st_r;
    logic [9:0] tx_shift_r;
    logic [3:0] tx_bits_r, hold_cnt_r;
    logic [15:0] tx_cnt_r;
    logic tx_load, tx_bit_end, tx_last;
    msl_pkg::msl_rx_state_e rx_st_r;
    logic [15:0] rx_cnt_r;
    logic [2:0] rx_bits_r;
    logic [7:0] rx_sr_r;
    logic rx_line, rx_bit_end, rx_push, rx_bad;
    logic fifo_in_ready;
    logic [5:0] fifo_count;

    assign enable = ctrl_r[`MSL_CTRL_EN];
    assign mode422 = (ctrl_r[`MSL_CTRL_LINE_HI:`MSL_CTRL_LINE_LO] == `MSL_LINE_RS422);
    assign mode485 = (ctrl_r[`MSL_CTRL_LINE_HI:`MSL_CTRL_LINE_LO] == `MSL_LINE_RS485);

    // ****************************************************************
    // AXI4-Lite slave
    // ****************************************************************
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign do_write = aw_held_r & w_held_r & !bvalid_r;
    assign rd_take = s_axi_arvalid & !rvalid_r;
    assign wr_hit = (aw_addr_r == `MSL_REG_CTRL) | (aw_addr_r == `MSL_REG_BAUD) |
                    (aw_addr_r == `MSL_REG_TOFF) | (aw_addr_r == `MSL_REG_STAT);

    // Byte lanes merged over the current register value
    always_comb begin
        logic [31:0] cur;
        cur = 32'h0;
        unique case (aw_addr_r)
            `MSL_REG_CTRL: cur = {24'h0, ctrl_r};
            `MSL_REG_BAUD: cur = {16'h0, baud_r};
            `MSL_REG_TOFF: cur = {28'h0, toff_r};
            default: cur = 32'h0;
        endcase
        for (int i = 0; i < 4; i++) begin
            wr_merge[i*8 +: 8] = w_strb_r[i] ? w_data_r[i*8 +: 8] : cur[i*8 +: 8];
        end
    end

    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            `MSL_REG_CTRL: rd_mux = {24'h0, ctrl_r};
            `MSL_REG_BAUD: rd_mux = {16'h0, baud_r};
            `MSL_REG_TOFF: rd_mux = {28'h0, toff_r};
            `MSL_REG_STAT: rd_mux = {10'h0, fifo_count, 6'h0, frm_r, ovr_r, 1'b0, rts_in, dtr_in,
                                     (tx_st_r != msl_pkg::MSL_TX_IDLE), bus_idle_ok, line_drv_en,
                                     cts_out, cd_out};
            default: begin
                rd_mux = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_held_r <= 1'b0;
            w_data_r <= 32'h0;
            w_strb_r <= 4'h0;
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= wr_hit ? 2'h0 : 2'h2;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= 2'h0;
        end else if (rd_take) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_mux;
            rresp_r <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r <= `MSL_CTRL_RST;
            baud_r <= `MSL_BAUD_DIV_RST;
            toff_r <= `MSL_TOFF_RST;
        end else if (do_write) begin
            if (aw_addr_r == `MSL_REG_CTRL) begin
                ctrl_r <= wr_merge[7:0];
            end
            // Any nonzero divisor, so the top host rate stays reachable
            if (aw_addr_r == `MSL_REG_BAUD && wr_merge[15:0] != 16'h0) begin
                baud_r <= wr_merge[15:0];
            end
            if (aw_addr_r == `MSL_REG_TOFF && wr_merge[3:0] != 4'h0) begin
                toff_r <= wr_merge[3:0];
            end
        end
    end

    // Error flags: hardware set wins over software clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ovr_r <= 1'b0;
            frm_r <= 1'b0;
        end else begin
            if (rx_push && !fifo_in_ready) begin
                ovr_r <= 1'b1;
            end else if (do_write && aw_addr_r == `MSL_REG_STAT && w_strb_r[1] && w_data_r[`MSL_STAT_OVR]) begin
                ovr_r <= 1'b0;
            end
            if (rx_bad) begin
                frm_r <= 1'b1;
            end else if (do_write && aw_addr_r == `MSL_REG_STAT && w_strb_r[1] && w_data_r[`MSL_STAT_FRM]) begin
                frm_r <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // Modem control lines
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cd_out <= 1'b0;
            cts_out <= 1'b0;
            dtr_ctl <= 1'b0;
            rts_ctl <= 1'b0;
        end else begin
            cd_out <= link_up;
            // Margin of one entry for a byte already in flight
            cts_out <= enable & (fifo_count < 6'(`MSL_FIFO_DEPTH - 1));
            rts_ctl <= rts_in & ctrl_r[`MSL_CTRL_RTSC];
            dtr_ctl <= dtr_in & ((ctrl_r[`MSL_CTRL_OP_HI:`MSL_CTRL_OP_LO] == `MSL_OP_SWITCHABLE) |
                                 ctrl_r[`MSL_CTRL_DTRC]);
        end
    end

    // ****************************************************************
    // Quarter-character tick and bus idle check
    // ****************************************************************
    assign q_len = 20'((20'(baud_r) * `MSL_QUARTERS) >> 2);
    assign q_tick = (q_cnt_r >= q_len - 20'h1);
    assign q_restart = tx_bit_end & tx_last;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            q_cnt_r <= 20'h0;
        end else if (q_restart || q_tick) begin
            q_cnt_r <= 20'h0;
        end else begin
            q_cnt_r <= q_cnt_r + 20'h1;
        end
    end

    // One quiet character on the pair before driving it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            idle_q_r <= 3'h0;
        end else if (!rxd_in || rx_st_r != msl_pkg::MSL_RX_IDLE) begin
            idle_q_r <= 3'h0;
        end else if (q_tick && !bus_idle_ok) begin
            idle_q_r <= idle_q_r + 3'h1;
        end
    end
    assign bus_idle_ok = (idle_q_r >= `MSL_BUS_IDLE_Q);

    // ****************************************************************
    // Transmitter toward the host
    // ****************************************************************
    // No address filter: every radio byte goes out the port
    assign tx_load = enable & radio_tx_valid &
                     (((tx_st_r == msl_pkg::MSL_TX_IDLE) & !mode485) |
                      ((tx_st_r == msl_pkg::MSL_TX_WAIT_BUS) & bus_idle_ok) |
                      (tx_st_r == msl_pkg::MSL_TX_HOLD));
    assign radio_tx_ready = tx_load;
    assign tx_bit_end = (tx_st_r == msl_pkg::MSL_TX_SHIFT) & (tx_cnt_r == baud_r - 16'h1);
    assign tx_last = (tx_bits_r == 4'h1);

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_st_r <= msl_pkg::MSL_TX_IDLE;
            tx_shift_r <= 10'h3ff;
            tx_bits_r <= 4'h0;
            tx_cnt_r <= 16'h0;
            hold_cnt_r <= 4'h0;
        end else if (tx_load) begin
            tx_st_r <= msl_pkg::MSL_TX_SHIFT;
            tx_shift_r <= {1'b1, radio_tx_data, 1'b0};
            tx_bits_r <= `MSL_CHAR_BITS;
            tx_cnt_r <= 16'h0;
        end else begin
            unique case (tx_st_r)
                msl_pkg::MSL_TX_IDLE: begin
                    if (enable && radio_tx_valid && mode485) begin
                        tx_st_r <= msl_pkg::MSL_TX_WAIT_BUS;
                    end
                end
                msl_pkg::MSL_TX_WAIT_BUS: begin
                    if (!enable) begin
                        tx_st_r <= msl_pkg::MSL_TX_IDLE;
                    end
                end
                msl_pkg::MSL_TX_SHIFT: begin
                    if (tx_bit_end) begin
                        tx_cnt_r <= 16'h0;
                        tx_shift_r <= {1'b1, tx_shift_r[9:1]};
                        tx_bits_r <= tx_bits_r - 4'h1;
                        if (tx_last) begin
                            tx_st_r <= mode485 ? msl_pkg::MSL_TX_HOLD : msl_pkg::MSL_TX_IDLE;
                            hold_cnt_r <= toff_r;
                        end
                    end else begin
                        tx_cnt_r <= tx_cnt_r + 16'h1;
                    end
                end
                msl_pkg::MSL_TX_HOLD: begin
                    if (q_tick) begin
                        hold_cnt_r <= hold_cnt_r - 4'h1;
                        if (hold_cnt_r <= 4'h1) begin
                            tx_st_r <= msl_pkg::MSL_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    assign txd_out = tx_shift_r[0];

    // RS-232 and RS-422 drive continuously; RS-485 only while it owns the pair
    assign line_drv_en = mode485 ? ((tx_st_r == msl_pkg::MSL_TX_SHIFT) | (tx_st_r == msl_pkg::MSL_TX_HOLD))
                                 : (mode422 | !mode485);

    // ****************************************************************
    // Receiver from the host
    // ****************************************************************
    // Own echo masked while driving a two-wire pair
    assign rx_line = (mode485 & line_drv_en) | rxd_in;
    assign rx_bit_end = (rx_cnt_r == baud_r - 16'h1);
    // CTS is the only handshake, in every line mode: a byte without FIFO room is an overrun
    assign rx_push = (rx_st_r == msl_pkg::MSL_RX_STOP) & rx_bit_end & rx_line;
    assign rx_bad = (rx_st_r == msl_pkg::MSL_RX_STOP) & rx_bit_end & !rx_line;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_st_r <= msl_pkg::MSL_RX_IDLE;
            rx_cnt_r <= 16'h0;
            rx_bits_r <= 3'h0;
            rx_sr_r <= 8'h00;
        end else begin
            rx_cnt_r <= rx_cnt_r + 16'h1;
            unique case (rx_st_r)
                msl_pkg::MSL_RX_IDLE: begin
                    rx_cnt_r <= 16'h0;
                    if (enable && !rx_line) begin
                        rx_st_r <= msl_pkg::MSL_RX_START;
                    end
                end
                msl_pkg::MSL_RX_START: begin
                    if (rx_cnt_r == (baud_r >> 1)) begin
                        rx_cnt_r <= 16'h0;
                        rx_bits_r <= 3'h0;
                        rx_st_r <= rx_line ? msl_pkg::MSL_RX_IDLE : msl_pkg::MSL_RX_DATA;
                    end
                end
                msl_pkg::MSL_RX_DATA: begin
                    if (rx_bit_end) begin
                        rx_cnt_r <= 16'h0;
                        rx_sr_r <= {rx_line, rx_sr_r[7:1]};
                        rx_bits_r <= rx_bits_r + 3'h1;
                        if (rx_bits_r == 3'h7) begin
                            rx_st_r <= msl_pkg::MSL_RX_STOP;
                        end
                    end
                end
                msl_pkg::MSL_RX_STOP: begin
                    if (rx_bit_end) begin
                        rx_st_r <= msl_pkg::MSL_RX_IDLE;
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // Receive buffer toward the radio
    // ****************************************************************
    msl_fifo #(
        .WIDTH(8),
        .DEPTH(`MSL_FIFO_DEPTH),
        .CW(`MSL_FIFO_CW)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .in_valid(rx_push),
        .in_ready(fifo_in_ready),
        .in_data(rx_sr_r),
        .out_valid(radio_rx_valid),
        .out_ready(radio_rx_ready),
        .out_data(radio_rx_data),
        .count(fifo_count)
    );
endmodule
`default_nettype wire

// ---- msl_serial_ctrl_asserts.sv ----
// Port checker of the host serial line controller.
// Assumes binding onto msl_serial_ctrl, CTRL writes with both channels together.
`timescale 1ns/100ps
`default_nettype none
module msl_serial_ctrl_asserts (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Serial side
    input wire logic txd_out,
    input wire logic cd_out,
    input wire logic line_drv_en,
    input wire logic link_up,
    input wire logic dtr_in,
    input wire logic rts_in,
    input wire logic dtr_ctl,
    input wire logic rts_ctl
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    logic [7:0] ctrl_r;
    // Shadow of the control register
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            ctrl_r <= 8'h01;
        else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == 8'h00)
            ctrl_r <= s_axi_wdata[7:0];
    end
    property p_cd; link_up |=> cd_out; endproperty
    a_cd: assert property (p_cd) else $error("carrier detect late");
    property p_start; $fell(txd_out) |-> !txd_out [*8]; endproperty
    a_start: assert property (p_start) else $error("start bit cut short");
    property p_drv_on; ctrl_r[2:1] != 2'h2 && $past(ctrl_r[2:1]) != 2'h2 |-> line_drv_en; endproperty
    a_drv_on: assert property (p_drv_on) else $error("driver off outside two-wire mode");
    property p_drv_start; ctrl_r[2:1] == 2'h2 && $rose(line_drv_en) |-> !txd_out; endproperty
    a_drv_start: assert property (p_drv_start) else $error("driver on without start bit");
    property p_release; ctrl_r[2:1] == 2'h2 && $fell(line_drv_en) |-> txd_out && $past(txd_out, 8); endproperty
    a_release: assert property (p_release) else $error("driver released too early");
    property p_rts; ctrl_r == $past(ctrl_r, 3) |-> rts_ctl == (ctrl_r[7] && $past(rts_in)); endproperty
    a_rts: assert property (p_rts) else $error("request line not gated");
    property p_dtr; ctrl_r == $past(ctrl_r, 3) |-> dtr_ctl == ((ctrl_r[5:3] == 3'h6 || ctrl_r[6]) && $past(dtr_in)); endproperty
    a_dtr: assert property (p_dtr) else $error("terminal ready not gated");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
bind msl_serial_ctrl msl_serial_ctrl_asserts u_chk (.*);
`default_nettype wire

// ---- msl_host_model.sv ----
// Behavioural host device on the serial line.
// Assumes a fixed bit period in clock cycles.
`timescale 1ns/100ps
`default_nettype none
module msl_host_model #(
    parameter int BIT = 16
) (
    // Line
    input wire logic sys_clk,
    input wire logic txd_out,
    input wire logic cts_out,
    output logic rxd_in
);
    logic [7:0] got [$];
    initial rxd_in = 1'b1;
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        while (!cts_out) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            rxd_in <= f[i];
            repeat (BIT) @(posedge sys_clk);
        end
    endtask
    // Mid-bit sampling of each character
    always begin
        logic [7:0] d;
        @(negedge txd_out);
        repeat (BIT / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge sys_clk);
            d[i] = txd_out;
        end
        repeat (BIT) @(posedge sys_clk);
        got.push_back(d);
    end
endmodule
`default_nettype wire

// ---- msl_serial_ctrl_tb.sv ----
// Self-checking bench of the host serial line controller.
// Assumes the host model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "msl_map.svh"
module msl_serial_ctrl_tb;
    localparam int BIT = 16;
    logic sys_clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, txd_out, rxd_in, cd_out, cts_out, dtr_in, rts_in;
    logic line_drv_en, link_up, radio_tx_valid, radio_tx_ready, radio_rx_valid, radio_rx_ready, dtr_ctl, rts_ctl;
    logic [7:0] s_axi_awaddr, s_axi_araddr, radio_tx_data, radio_rx_data, b;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
    logic [7:0] eq [$];
    integer seed = 32'h5fad78fa;
    int fails = 0;
    int checks = 0;
    int n;
    function automatic int hold_len(input int q);
        return 10 * BIT + q * (BIT * 10 / 4);
    endfunction
    msl_serial_ctrl DUT (.*);
    msl_host_model #(.BIT(BIT)) u_host (.sys_clk(sys_clk), .txd_out(txd_out), .cts_out(cts_out), .rxd_in(rxd_in));
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        if (fails == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        fork
            begin do @(posedge sys_clk); while (!s_axi_awready); s_axi_awvalid <= 1'b0; end
            begin do @(posedge sys_clk); while (!s_axi_wready); s_axi_wvalid <= 1'b0; end
        join
        s_axi_bready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_bvalid);
        rd_r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] a);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr <= a;
        do @(posedge sys_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (!s_axi_rvalid);
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic tx(input logic [7:0] d);
        radio_tx_valid <= 1'b1;
        radio_tx_data <= d;
        do @(posedge sys_clk); while (!radio_tx_ready);
        radio_tx_valid <= 1'b0;
        @(posedge sys_clk);
    endtask
    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        complete_run();
    end
    initial begin
        reset_n = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {radio_tx_valid, radio_rx_ready, link_up, dtr_in, rts_in} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, radio_tx_data} = '0;
        s_axi_wstrb = 4'hf;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        @(posedge sys_clk);
        rd(`MSL_REG_CTRL);
        chk("ctrl", 32'h1, rd_d);
        rd(`MSL_REG_BAUD);
        chk("baud", 32'h15b, rd_d);
        rd(8'h10);
        chk("resp", 32'h2, 32'(rd_r));
        wr(`MSL_REG_BAUD, BIT);
        wr(`MSL_REG_TOFF, 32'h0);
        chk("bresp", 32'h0, 32'(rd_r));
        rd(`MSL_REG_TOFF);
        chk("toff", 32'h4, rd_d);
        for (int i = 0; i < 4; i++) begin
            link_up <= 1'($random(seed));
            repeat (2) @(posedge sys_clk);
            chk("cd", 32'(link_up), 32'(cd_out));
        end
        for (int i = 0; i < 3; i++) begin
            b = 8'($random(seed));
            eq.push_back(b);
            tx(b);
        end
        for (n = 0; u_host.got.size() < 3 && n < 2000; n++) @(posedge sys_clk);
        foreach (eq[i]) chk("to host", 32'(eq[i]), 32'(u_host.got[i]));
        eq.delete();
        for (int i = 0; i < 31; i++) begin
            b = 8'($random(seed));
            eq.push_back(b);
            u_host.send(b);
        end
        repeat (BIT) @(posedge sys_clk);
        chk("cts", 32'h0, 32'(cts_out));
        rd(`MSL_REG_STAT);
        chk("fill", 32'h1f, 32'(rd_d[21:16]));
        foreach (eq[i]) begin
            for (n = 0; !radio_rx_valid && n < 500; n++) @(posedge sys_clk);
            fails += (n == 500);
            chk("from host", 32'(eq[i]), 32'(radio_rx_data));
            radio_rx_ready <= 1'b1;
            @(posedge sys_clk);
            radio_rx_ready <= 1'b0;
            @(posedge sys_clk);
        end
        wr(`MSL_REG_CTRL, 32'h5);
        b = 8'($random(seed));
        tx(b);
        for (n = 0; !line_drv_en && n < 500; n++) @(posedge sys_clk);
        for (n = 0; line_drv_en && n < 2000; n++) @(posedge sys_clk);
        chk("drv hold", hold_len(`MSL_TOFF_RST), n);
        chk("to host", 32'(b), 32'(u_host.got[3]));
        wr(`MSL_REG_CTRL, 32'h3);
        chk("drv 422", 32'h1, 32'(line_drv_en));
        dtr_in <= 1'b1;
        rts_in <= 1'b1;
        wr(`MSL_REG_CTRL, 32'h81);
        repeat (3) @(posedge sys_clk);
        chk("rts", 32'h1, 32'(rts_ctl));
        chk("dtr", 32'h0, 32'(dtr_ctl));
        wr(`MSL_REG_CTRL, 32'h41);
        repeat (3) @(posedge sys_clk);
        chk("dtr", 32'h1, 32'(dtr_ctl));
        complete_run();
    end
endmodule
`default_nettype wire
